//--- logic/tlpr_ecc_byte.sv
`default_nettype none

package tlpr_pkg;
    localparam int BUS_BITS = 64;
    localparam int BUS_BYTES = BUS_BITS / 8;
    localparam int CHK_BITS = 5;
    localparam int BUF_DEPTH = 8;
    localparam int PTR_BITS = 3;
    localparam int CNT_BITS = 4;
    localparam int ACCEPT_LATENCY = 2;
    localparam int NP_LIMIT_64 = 14;
    localparam int NP_LIMIT_128 = 26;
    localparam int NP_CNT_BITS = 5;
    localparam logic [NP_CNT_BITS-1:0] NP_LIMIT =
        (BUS_BITS == 128) ? NP_CNT_BITS'(NP_LIMIT_128) : NP_CNT_BITS'(NP_LIMIT_64);
    localparam logic [PTR_BITS-1:0] PTR_RESET = 3'h0;
    localparam logic [CNT_BITS-1:0] CNT_RESET = 4'h0;
    localparam logic [CNT_BITS-1:0] CNT_FULL = CNT_BITS'(BUF_DEPTH);
    localparam logic [NP_CNT_BITS-1:0] NP_CNT_RESET = 5'h00;

    typedef enum logic [0:0] {
        ST_PASS = 1'b0,
        ST_DISCARD = 1'b1
    } tlpr_state_e;

    // Hamming check bits plus overall parity for one stored byte
    function automatic logic [CHK_BITS-1:0] tlpr_ecc_encode(input logic [7:0] d);
        logic [3:0] p;
        p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        return {(^d) ^ (^p), p};
    endfunction
endpackage

module tlpr_ecc_byte (
    input wire logic [7:0] data_in, // Stored byte
    input wire logic [tlpr_pkg::CHK_BITS-1:0] chk_in, // Stored check bits
    output logic [7:0] data_out, // Corrected byte
    output logic single_err, // One bit was wrong and fixed
    output logic double_err // Two bits wrong, not fixable
);
    logic [tlpr_pkg::CHK_BITS-1:0] recomputed;
    logic [3:0] syndrome;
    logic parity_bad;
    logic [7:0] flip_mask;

    // Syndrome and overall parity decide the error class
    assign recomputed = tlpr_pkg::tlpr_ecc_encode(data_in);
    assign syndrome = recomputed[3:0] ^ chk_in[3:0];
    assign parity_bad = (^data_in) ^ (^chk_in);
    assign single_err = parity_bad;
    assign double_err = !parity_bad && (syndrome != 4'h0);
    assign data_out = data_in ^ flip_mask;

    // Syndrome points at the flipped position; check-bit hits leave data alone
    always_comb begin
        flip_mask = 8'h00;
        if (parity_bad) begin
            case (syndrome)
                4'h3: flip_mask = 8'h01;
                4'h5: flip_mask = 8'h02;
                4'h6: flip_mask = 8'h04;
                4'h7: flip_mask = 8'h08;
                4'h9: flip_mask = 8'h10;
                4'hA: flip_mask = 8'h20;
                4'hB: flip_mask = 8'h40;
                4'hC: flip_mask = 8'h80;
                default: flip_mask = 8'h00;
            endcase
        end
    end
endmodule

`default_nettype wire

//--- logic/tlpr_rx_stream.sv
// Summary of operation
// [RULE1] Beat-valid falls within 2 cycles after the application drops ready.
// [RULE2] Beat-valid returns within 2 cycles of ready when data waits.
// [RULE3] Beat-valid may gap inside a packet; the application tolerates it.
// [RULE4] Fault output reports uncorrectable buffer ECC errors, only with ECC enabled.
// [RULE5] Buffer ECC fixes single-bit and flags double-bit errors per byte.
// [RULE6] Fault stays high at least one cycle together with beat-valid.
// [RULE7] Error before payload end may cut the packet; valid drops next cycle.
// [RULE8] After a double-bit fault the application should reset the core.
// [RULE9] Hold-off stops new non-posted requests from starting toward the application.
// [RULE10] Non-posted requests already handed over are untouched by hold-off.
// [RULE11] At most 14 (64-bit) or 26 (128-bit) non-posted after hold-off.
// [RULE12] Ready latency is 2: ready on cycle n allows a beat on n+2.
// [RULE13] First beat marked by packet-first, last beat by packet-last, with valid.
// [RULE14] Payload bus is 64 or 128 bits wide, fixed at build time.
// [RULE15] Posted requests and completions keep flowing while hold-off is high; here any queued behind a held non-posted start wait.
// [RULE16] After hold-off drops, resumed non-posted follow the normal handshake.
`default_nettype none

module tlpr_rx_stream (
    input wire logic clk, // 200 MHz core clock
    input wire logic reset, // Synchronous, active high
    input wire logic ecc_enable, // Buffer ECC checking on
    // Transaction layer side
    input wire logic tl_valid, // Beat offered by the transaction layer
    output logic tl_ready, // Buffer has room
    input wire logic [tlpr_pkg::BUS_BITS-1:0] tl_data, // Beat data
    input wire logic tl_first, // First beat of a TLP
    input wire logic tl_last, // Last beat of a TLP
    input wire logic tl_nonposted, // TLP is a non-posted request
    input wire logic [tlpr_pkg::BUS_BITS-1:0] tl_fault_inject, // Bits flipped on store
    output logic tl_np_stall, // Do not offer new non-posted TLPs
    // Application side
    input wire logic app_accept_ready, // Application can take beats
    input wire logic nonposted_holdoff, // Application asks to hold non-posted
    output logic rx_beat_valid, // Beat present
    output logic [tlpr_pkg::BUS_BITS-1:0] rx_payload_bus, // Beat data
    output logic rx_packet_first, // First beat of packet
    output logic rx_packet_last, // Last beat of packet
    output logic rx_buffer_ecc_fault // Uncorrectable buffer error
);
    localparam int BB = tlpr_pkg::BUS_BYTES;
    localparam int CB = tlpr_pkg::CHK_BITS;

    // Receive buffer entries, flip-flop storage
    logic [tlpr_pkg::BUS_BITS-1:0] mem_data [tlpr_pkg::BUF_DEPTH];
    logic [BB*CB-1:0] mem_chk [tlpr_pkg::BUF_DEPTH];
    logic mem_first [tlpr_pkg::BUF_DEPTH];
    logic mem_last [tlpr_pkg::BUF_DEPTH];
    logic mem_np [tlpr_pkg::BUF_DEPTH];

    // Buffer pointers, occupancy and control state
    logic [tlpr_pkg::PTR_BITS-1:0] wr_ptr;
    logic [tlpr_pkg::PTR_BITS-1:0] rd_ptr;
    logic [tlpr_pkg::CNT_BITS-1:0] count;
    logic [tlpr_pkg::CNT_BITS-1:0] next_count;
    logic [tlpr_pkg::NP_CNT_BITS-1:0] np_count;
    logic ready_d1;
    tlpr_pkg::tlpr_state_e state;
    tlpr_pkg::tlpr_state_e next_state;

    // Head-of-buffer decode and handshake nets
    logic [BB*CB-1:0] enc_chk;
    logic [tlpr_pkg::BUS_BITS-1:0] head_raw;
    logic [tlpr_pkg::BUS_BITS-1:0] head_fixed;
    logic [tlpr_pkg::BUS_BITS-1:0] head_out;
    logic [BB-1:0] byte_double;
    logic head_first;
    logic head_last;
    logic head_np;
    logic head_uncorr;
    logic buf_empty;
    logic np_block;
    logic can_present;
    logic pop;
    logic push;
    logic truncate;
    logic in_pass;
    logic np_start;
    logic np_at_limit;
    logic beat_end;
    logic discard_pop;

    // Per-byte encode on store and decode at the buffer head
    assign head_raw = mem_data[rd_ptr];
    generate
        for (genvar b = 0; b < BB; b++) begin : g_byte
            assign enc_chk[b*CB +: CB] = tlpr_pkg::tlpr_ecc_encode(tl_data[b*8 +: 8]);
            tlpr_ecc_byte u_dec (
                .data_in(head_raw[b*8 +: 8]),
                .chk_in(mem_chk[rd_ptr][b*CB +: CB]),
                .data_out(head_fixed[b*8 +: 8]),
                .single_err(), // Repaired in place, nothing to report
                .double_err(byte_double[b])
            ); // [RULE5]
        end
    endgenerate

    // Head decode; with ECC off the raw word passes and no fault is raised
    // A byte with two flipped bits cannot be repaired, so the beat is flagged
    assign head_first = mem_first[rd_ptr];
    assign head_last = mem_last[rd_ptr];
    assign head_np = mem_np[rd_ptr];
    assign head_out = ecc_enable ? head_fixed : head_raw; // [RULE5]
    assign head_uncorr = ecc_enable && (|byte_double); // [RULE4]
    assign buf_empty = (count == tlpr_pkg::CNT_RESET);
    assign beat_end = head_last || head_uncorr; // [RULE7]
    assign in_pass = (state == tlpr_pkg::ST_PASS);
    assign discard_pop = (state == tlpr_pkg::ST_DISCARD) && !buf_empty;

    // Non-posted start at the head, and whether the hold-off budget is spent
    assign np_start = head_first && head_np;
    assign np_at_limit = (np_count >= tlpr_pkg::NP_LIMIT); // [RULE11]

    // Only a non-posted start at the head is held, and only at the limit,
    // so posted and completion traffic keeps moving in the normal case
    assign np_block = nonposted_holdoff && np_start && np_at_limit; // [RULE11] [RULE15]

    // A beat goes out only on a ready cycle, two after the ready sample
    assign can_present = in_pass && ready_d1 &&
                         !buf_empty && !np_block; // [RULE12] [RULE1] [RULE2] [RULE3]
    assign pop = can_present || discard_pop;
    assign push = tl_valid && tl_ready;
    assign truncate = can_present && head_uncorr && !head_last; // [RULE7]
    assign next_count = count + tlpr_pkg::CNT_BITS'(push) - tlpr_pkg::CNT_BITS'(pop);

    // Truncated packets drain their remaining beats unseen; draining
    // ignores ready, since nothing from them reaches the application
    always_comb begin
        next_state = state;
        case (state)
            tlpr_pkg::ST_PASS: begin
                if (truncate) begin
                    next_state = tlpr_pkg::ST_DISCARD; // [RULE7]
                end
            end
            tlpr_pkg::ST_DISCARD: begin
                if (pop && head_last) begin
                    next_state = tlpr_pkg::ST_PASS;
                end
            end
            default: next_state = tlpr_pkg::ST_PASS;
        endcase
    end

    // Buffer storage, no reset needed on the data
    // Check bits come from the clean beat, so an injected flip acts as an upset
    always_ff @(posedge clk) begin
        if (push) begin
            mem_data[wr_ptr] <= tl_data ^ tl_fault_inject;
            mem_chk[wr_ptr] <= enc_chk;
            mem_first[wr_ptr] <= tl_first;
            mem_last[wr_ptr] <= tl_last;
            mem_np[wr_ptr] <= tl_nonposted;
        end
    end

    // Pointers, occupancy, state and back-pressure
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= tlpr_pkg::PTR_RESET;
            rd_ptr <= tlpr_pkg::PTR_RESET;
            count <= tlpr_pkg::CNT_RESET;
            state <= tlpr_pkg::ST_PASS;
            tl_ready <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + tlpr_pkg::PTR_BITS'(push);
            rd_ptr <= rd_ptr + tlpr_pkg::PTR_BITS'(pop);
            count <= next_count;
            state <= next_state;
            tl_ready <= (next_count != tlpr_pkg::CNT_FULL);
        end
    end

    // Hold-off: stall new non-posted at the source from the next cycle; entries
    // already buffered still flow, counted against the limit
    always_ff @(posedge clk) begin
        if (reset) begin
            tl_np_stall <= 1'b0;
            np_count <= tlpr_pkg::NP_CNT_RESET;
        end else begin
            tl_np_stall <= nonposted_holdoff; // [RULE9] [RULE10]
            if (!nonposted_holdoff) begin
                np_count <= tlpr_pkg::NP_CNT_RESET; // [RULE16]
            end else if (can_present && np_start) begin
                np_count <= np_count + 5'h01; // [RULE11]
            end
        end
    end

    // Ready sample: first of the two latency stages, the output flop is the second
    always_ff @(posedge clk) begin
        if (reset) begin
            ready_d1 <= 1'b0;
        end else begin
            ready_d1 <= app_accept_ready; // [RULE12]
        end
    end

    // Registered beat flags; all are low between beats
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_beat_valid <= 1'b0;
            rx_packet_first <= 1'b0;
            rx_packet_last <= 1'b0;
            rx_buffer_ecc_fault <= 1'b0;
        end else begin
            rx_beat_valid <= can_present; // [RULE1] [RULE2]
            rx_packet_first <= can_present && head_first; // [RULE13]
            rx_packet_last <= can_present && beat_end; // [RULE13] [RULE7]
            rx_buffer_ecc_fault <= can_present && head_uncorr; // [RULE4] [RULE6]
        end
    end

    // Payload holds the last beat between beats, which saves toggling a wide bus
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_payload_bus <= '0;
        end else if (can_present) begin
            rx_payload_bus <= head_out; // [RULE14]
        end
    end
endmodule

`default_nettype wire

//--- verif/tlpr_rx_properties.sv
`default_nettype none
module tlpr_rx_properties (
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic ecc_enable, // ECC on
    input wire logic app_accept_ready, // Ready
    input wire logic nonposted_holdoff, // Hold-off
    input wire logic tl_np_stall, // Stall
    input wire logic rx_beat_valid, // Beat
    input wire logic rx_packet_first, // First
    input wire logic rx_packet_last, // Last
    input wire logic rx_buffer_ecc_fault // Fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic in_pkt;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Set between a first beat and its last beat
    always_ff @(posedge clk) begin
        if (reset) begin
            in_pkt <= 1'b0;
        end else if (rx_beat_valid) begin
            in_pkt <= !rx_packet_last;
        end
    end
    ready_latency_a: assert property (rx_beat_valid |-> $past(app_accept_ready, 2))
        else $error("beat without ready");
    ready_drop_a: assert property ($fell(app_accept_ready) |-> ##2 !rx_beat_valid)
        else $error("beat after ready drop");
    stall_follow_a: assert property (nonposted_holdoff |=> tl_np_stall)
        else $error("stall missing");
    first_frame_a: assert property (rx_beat_valid && !in_pkt |-> rx_packet_first)
        else $error("first flag missing");
    mid_frame_a: assert property (rx_beat_valid && in_pkt |-> !rx_packet_first)
        else $error("first flag inside packet");
    flag_qual_a: assert property (rx_packet_first || rx_packet_last || rx_buffer_ecc_fault
        |-> rx_beat_valid) else $error("flag without beat");
    fault_cut_a: assert property (rx_buffer_ecc_fault |-> rx_packet_last)
        else $error("fault beat not last");
    ecc_off_a: assert property (!$past(ecc_enable) |-> !rx_buffer_ecc_fault)
        else $error("fault with ECC off");
endmodule
bind tlpr_rx_stream tlpr_rx_properties chk (.clk(clk), .reset(reset), .ecc_enable(ecc_enable),
    .app_accept_ready(app_accept_ready), .nonposted_holdoff(nonposted_holdoff),
    .tl_np_stall(tl_np_stall), .rx_beat_valid(rx_beat_valid), .rx_packet_first(rx_packet_first),
    .rx_packet_last(rx_packet_last), .rx_buffer_ecc_fault(rx_buffer_ecc_fault));
`default_nettype wire

//--- verif/tlpr_app_model.sv
`default_nettype none
module tlpr_app_model (
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic slow, // Throttle ready
    output logic app_accept_ready, // To device
    input wire logic rx_beat_valid, // Beat
    input wire logic [tlpr_pkg::BUS_BITS-1:0] rx_payload_bus, // Data
    input wire logic rx_packet_first, // First
    input wire logic rx_packet_last, // Last
    input wire logic rx_buffer_ecc_fault // Fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    logic [tlpr_pkg::BUS_BITS+2:0] got[$];
    // Slow mode toggles ready so packets get gaps
    always_ff @(posedge clk) begin
        phase <= reset ? 2'h0 : phase + 2'h1;
        app_accept_ready <= !slow || phase[1];
    end
    // Every beat is kept, cut packets too
    always_ff @(posedge clk) begin
        if (!reset && rx_beat_valid) begin
            got.push_back({rx_buffer_ecc_fault, rx_packet_first, rx_packet_last, rx_payload_bus});
        end
    end
endmodule
`default_nettype wire

//--- verif/test_tlp_rx_stream_handshake.sv
`default_nettype none
module test_tlp_rx_stream_handshake;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, ecc_enable = 1, tl_valid = 0, tl_first = 0, tl_last = 0;
    logic tl_nonposted = 0, slow = 0, nonposted_holdoff = 0, app_accept_ready, tl_ready;
    logic tl_np_stall, rx_beat_valid, rx_packet_first, rx_packet_last, rx_buffer_ecc_fault;
    logic [tlpr_pkg::BUS_BITS-1:0] tl_data = 0, tl_fault_inject = 0, rx_payload_bus;
    int errors = 0, checks_done = 0, base;
    always #2.5 clk = ~clk;
    tlpr_rx_stream dut (.clk(clk), .reset(reset), .ecc_enable(ecc_enable), .tl_valid(tl_valid),
        .tl_ready(tl_ready), .tl_data(tl_data), .tl_first(tl_first), .tl_last(tl_last),
        .tl_nonposted(tl_nonposted), .tl_fault_inject(tl_fault_inject), .tl_np_stall(tl_np_stall),
        .app_accept_ready(app_accept_ready), .nonposted_holdoff(nonposted_holdoff),
        .rx_beat_valid(rx_beat_valid), .rx_payload_bus(rx_payload_bus),
        .rx_packet_first(rx_packet_first), .rx_packet_last(rx_packet_last),
        .rx_buffer_ecc_fault(rx_buffer_ecc_fault));
    tlpr_app_model app (.clk(clk), .reset(reset), .slow(slow), .app_accept_ready(app_accept_ready),
        .rx_beat_valid(rx_beat_valid), .rx_payload_bus(rx_payload_bus),
        .rx_packet_first(rx_packet_first), .rx_packet_last(rx_packet_last),
        .rx_buffer_ecc_fault(rx_buffer_ecc_fault));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [66:0] seen, input logic [66:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Beat held until an edge where tl_ready is high; caller lowers tl_valid
    task automatic send(input logic [63:0] d, input logic f, l, np, input logic [63:0] inj);
        int n;
        n = 0;
        tl_valid = 1'b1;
        {tl_data, tl_first, tl_last, tl_nonposted, tl_fault_inject} = {d, f, l, np, inj};
        while (tl_ready !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        if (n == 300) begin
            errors++;
            $display("unexpected tl_ready: expected 1 seen %b", tl_ready);
            end_of_test();
        end
        cyc(1);
    endtask
    task automatic waitn(input int k);
        int n;
        n = 0;
        while (app.got.size() < base + k && n < 300) begin
            cyc(1);
            n++;
        end
        if (n == 300) begin
            errors++;
            $display("unexpected beat count: expected %0d seen %0d", base + k, app.got.size());
            end_of_test();
        end
    endtask
    task automatic t_frames();
        base = app.got.size();
        slow = 1'b1;
        send(64'hA5A5_0001_0000_0001, 1'b1, 1'b1, 1'b0, 64'h0);
        for (int i = 0; i < 3; i++) begin
            send(64'h1111_0000_0000_0000 + i, i == 0, i == 2, 1'b0, 64'h0);
        end
        tl_valid = 1'b0;
        waitn(4);
        chk("single", app.got[base], {3'h3, 64'hA5A5_0001_0000_0001});
        for (int i = 0; i < 3; i++) begin
            chk("multi", app.got[base + 1 + i], {1'b0, i == 0, i == 2, 64'h1111_0000_0000_0000 + i});
        end
        slow = 1'b0;
        $display("frames end");
    endtask
    task automatic t_ecc();
        base = app.got.size();
        send(64'hC0, 1'b1, 1'b1, 1'b0, 64'h10);
        send(64'hD0, 1'b1, 1'b0, 1'b0, 64'h0);
        send(64'hD1, 1'b0, 1'b0, 1'b0, 64'h0300_0000);
        send(64'hD2, 1'b0, 1'b1, 1'b0, 64'h0);
        send(64'hE0, 1'b1, 1'b1, 1'b0, 64'h0);
        tl_valid = 1'b0;
        waitn(4);
        chk("corrected", app.got[base], {3'h3, 64'hC0});
        chk("fault flags", {64'h0, app.got[base + 2][66:64]}, 67'h5);
        chk("after cut", app.got[base + 3], {3'h3, 64'hE0});
        ecc_enable = 1'b0;
        send(64'hF0, 1'b1, 1'b1, 1'b0, 64'h0300_0000);
        tl_valid = 1'b0;
        waitn(5);
        chk("raw", app.got[base + 4], {3'h3, 64'h0300_00F0});
        ecc_enable = 1'b1;
        reset = 1'b1; // Core reset after the fault
        cyc(2);
        reset = 1'b0;
        $display("ecc end");
    endtask
    task automatic t_hold();
        nonposted_holdoff = 1'b1;
        cyc(2);
        base = app.got.size();
        chk("stall", {66'h0, tl_np_stall}, 67'h1);
        for (int i = 0; i <= 16; i++) begin
            send(64'hB0 + i, 1'b1, 1'b1, i != 0, 64'h0);
        end
        tl_valid = 1'b0;
        cyc(40);
        chk("held count", 67'(app.got.size() - base), 67'd15);
        chk("posted", app.got[base], {3'h3, 64'hB0});
        nonposted_holdoff = 1'b0;
        waitn(17);
        chk("resumed", app.got[base + 16], {3'h3, 64'hC0});
        $display("holdoff end");
    endtask
    initial begin
        cyc(16);
        reset = 1'b0;
        t_frames();
        t_ecc();
        t_hold();
        end_of_test();
    end
endmodule
`default_nettype wire
